/* File: scs_clock_select.sv */
// system clock source selection: direct, prescaler, pll and wakeup paths
//
// Operation
// RULE1: select 11 passes the direct clock input straight through.
// RULE2: select 10 with vco bypass 1 divides prescaler input by field plus one.
// RULE3: prescaler input is oscillator pin or internal source, chosen by software.
// RULE4: divide factor 1 passes oscillator unchanged, keeping its duty cycle.
// RULE5: largest divide factor is 1024.
// RULE6: select 10 with vco bypass 0 takes the pll clock.
// RULE7: select 00 takes the wakeup clock directly.
// RULE8: ten-bit divider field, factors 1 to 1024, switching without glitches.
`timescale 1ns/1ps
module scs_clock_select
	import scs_pkg::*;
#(
	parameter int DIV_W = SCS_DIV_W
) (
	// clock and reset
	input  wire logic                 ref_clk_in,
	input  wire logic                 sys_rst_in,
	// configuration
	input  wire logic [SCS_SEL_W-1:0] clock_source_select_in,
	input  wire logic                 vco_bypass_in,
	input  wire logic [DIV_W-1:0]     prescaler_divider_field_in,
	input  wire logic                 osc_use_internal_in,
	// source clocks, sampled as levels
	input  wire logic                 direct_clock_input_in,
	input  wire logic                 oscillator_input_pin_in,
	input  wire logic                 internal_clock_in,
	input  wire logic                 pll_clock_in,
	input  wire logic                 wakeup_clock_in,
	// outputs
	output logic                      sys_clk_out,
	output logic [3:0]                active_source_out
);
	// two-stage synchronisers, one per source level; only stage two is read
	localparam int NSRC = 5;
	wire  [NSRC-1:0] raw = {wakeup_clock_in, pll_clock_in, internal_clock_in,
		oscillator_input_pin_in, direct_clock_input_in};
	wire  [NSRC-1:0] sync2;

	genvar g;
	generate
		for (g = 0; g < NSRC; g++) begin : g_sync
			logic s1_reg;
			logic s2_reg;
			always_ff @(posedge ref_clk_in) begin
				if (sys_rst_in) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
				end else begin
					s1_reg <= raw[g];
					s2_reg <= s1_reg;
				end
			end
			assign sync2[g] = s2_reg;
		end
	endgenerate

	wire s_direct = sync2[0];
	wire s_osc    = sync2[1];
	wire s_int    = sync2[2];
	wire s_pll    = sync2[3];
	wire s_wake   = sync2[4];

	// configuration from software may change any time; sample it once
	logic [SCS_SEL_W-1:0] sel_reg;
	logic                 byp_reg;
	logic                 osel_reg;
	logic [DIV_W-1:0]     div_reg;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in)
			sel_reg <= SCS_SEL_RST;
		else
			sel_reg <= clock_source_select_in;
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in)
			byp_reg <= 1'b0;
		else
			byp_reg <= vco_bypass_in;
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in)
			osel_reg <= 1'b0;
		else
			osel_reg <= osc_use_internal_in;
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in)
			div_reg <= SCS_DIV_RST[DIV_W-1:0];
		else
			div_reg <= prescaler_divider_field_in;
	end

	function automatic scs_src_t decode_src(input logic [SCS_SEL_W-1:0] sel,
		input logic byp);
		unique case (sel)
			SCS_SEL_DIRECT: decode_src = SCS_SRC_DIRECT;                    // RULE1
			SCS_SEL_PRESC:  decode_src = byp ? SCS_SRC_PRESC : SCS_SRC_PLL; // RULE2 RULE6
			SCS_SEL_WAKEUP: decode_src = SCS_SRC_WAKEUP;                    // RULE7
			// code 01 has no source of its own, so it falls back to wakeup
			default:        decode_src = SCS_SRC_WAKEUP;
		endcase
	endfunction

	scs_src_t src_sel;
	assign src_sel = decode_src(sel_reg, byp_reg);

	// prescaler input source; edges of it step the divider
	wire presc_in = osel_reg ? s_int : s_osc; // RULE3
	logic presc_in_d_reg;
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in)
			presc_in_d_reg <= 1'b0;
		else
			presc_in_d_reg <= presc_in;
	end
	wire presc_rise = presc_in & ~presc_in_d_reg;

	// the divider runs in the sampled domain, stepped per input rising edge;
	// a factor change waits for the end of the running period
	logic presc_lvl;
	logic presc_unity;
	scs_prescaler #(.DIV_W(DIV_W)) u_presc (
		.ref_clk_in    (ref_clk_in),
		.sys_rst_in    (sys_rst_in),
		.step_in       (presc_rise),
		.div_value_in  (div_reg),
		.div_tick_out  (),
		.div_level_out (presc_lvl),
		.div_unity_out (presc_unity)
	);

	// factor 1 follows the input itself so the duty cycle is kept
	wire presc_out = presc_unity ? presc_in : presc_lvl; // RULE4

	// glitch-free switch: change source only while both old and new are low
	scs_src_t cur_reg;
	logic     clk_reg;
	logic     cur_lvl;
	logic     new_lvl;

	function automatic logic src_level(input scs_src_t s, input logic d,
		input logic p, input logic pl, input logic w);
		unique case (s)
			SCS_SRC_DIRECT: src_level = d;
			SCS_SRC_PRESC:  src_level = p;
			SCS_SRC_PLL:    src_level = pl;
			SCS_SRC_WAKEUP: src_level = w;
			default:        src_level = 1'b0;
		endcase
	endfunction

	assign cur_lvl = src_level(cur_reg, s_direct, presc_out, s_pll, s_wake);
	assign new_lvl = src_level(src_sel, s_direct, presc_out, s_pll, s_wake);

	// switching while both are low means no shortened high phase can appear
	wire switch_ok = (cur_reg != src_sel) && !cur_lvl && !new_lvl;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in)
			cur_reg <= SCS_SRC_WAKEUP;
		else if (switch_ok)
			cur_reg <= src_sel; // RULE8
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in)
			clk_reg <= 1'b0;
		else
			clk_reg <= cur_lvl; // RULE1 RULE7
	end

	assign sys_clk_out       = clk_reg;
	assign active_source_out = cur_reg;
endmodule // scs_clock_select

/* File: scs_pkg.sv */
// constants and types for the system clock source selector
package scs_pkg;
	localparam int          SCS_SEL_W       = 2;
	localparam int          SCS_DIV_W       = 10;
	localparam logic [1:0]  SCS_SEL_WAKEUP  = 2'h0;
	localparam logic [1:0]  SCS_SEL_PRESC   = 2'h2;
	localparam logic [1:0]  SCS_SEL_DIRECT  = 2'h3;
	localparam logic [1:0]  SCS_SEL_RST     = 2'h0;
	localparam logic [9:0]  SCS_DIV_RST     = 10'h000;
	localparam logic [10:0] SCS_DIV_MAX_FAC = 11'h400;
	localparam logic [9:0]  SCS_CNT_RST     = 10'h000;

	typedef enum logic [3:0] {
		SCS_SRC_WAKEUP = 4'b0001,
		SCS_SRC_PLL    = 4'b0010,
		SCS_SRC_PRESC  = 4'b0100,
		SCS_SRC_DIRECT = 4'b1000
	} scs_src_t;
endpackage

/* File: scs_prescaler.sv */
// divide-by-(n+1) prescaler with glitch-free divider reload
`timescale 1ns/1ps
module scs_prescaler
	import scs_pkg::*;
#(
	parameter int DIV_W = SCS_DIV_W
) (
	// clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             sys_rst_in,
	// divider control
	input  wire logic             step_in,
	input  wire logic [DIV_W-1:0] div_value_in,
	// divided output
	output logic                  div_tick_out,
	output logic                  div_level_out,
	output logic                  div_unity_out
);
	logic [DIV_W-1:0] cnt_reg;
	logic [DIV_W-1:0] cnt_next;
	logic [DIV_W-1:0] div_reg;
	logic             lvl_reg;
	logic             lvl_next;
	wire              wrap = (cnt_reg == div_reg);
	wire  [DIV_W-1:0] half = div_reg >> 1;

	// new divider is only taken at a period boundary so no runt pulse appears
	assign cnt_next = wrap ? SCS_CNT_RST[DIV_W-1:0] : cnt_reg + 1'b1; // RULE8
	assign lvl_next = (cnt_next <= (half)) ? 1'b1 : 1'b0;             // RULE5

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cnt_reg <= SCS_CNT_RST[DIV_W-1:0];
			div_reg <= SCS_DIV_RST[DIV_W-1:0];
			lvl_reg <= 1'b0;
		end else if (step_in) begin
			cnt_reg <= cnt_next; // RULE2
			lvl_reg <= lvl_next;
			if (wrap) begin
				div_reg <= div_value_in; // RULE8
			end
		end
	end

	assign div_tick_out  = wrap;
	assign div_level_out = lvl_reg;
	assign div_unity_out = (div_reg == {DIV_W{1'b0}}); // RULE4
endmodule // scs_prescaler

/* File: scs_clock_select_props.sv */
// port checks for the clock source selector
`timescale 1ns/1ps
module scs_clock_select_props
	import scs_pkg::*;
#(
	parameter int DIV_W = SCS_DIV_W
) (
	// clock and reset
	input wire logic                 ref_clk_in,
	input wire logic                 sys_rst_in,
	// configuration
	input wire logic [SCS_SEL_W-1:0] clock_source_select_in,
	input wire logic                 vco_bypass_in,
	input wire logic [DIV_W-1:0]     prescaler_divider_field_in,
	input wire logic                 osc_use_internal_in,
	// sources
	input wire logic                 direct_clock_input_in,
	input wire logic                 oscillator_input_pin_in,
	input wire logic                 internal_clock_in,
	input wire logic                 pll_clock_in,
	input wire logic                 wakeup_clock_in,
	// outputs
	input wire logic                 sys_clk_out,
	input wire logic [3:0]           active_source_out
);
	logic [7:0]       cnt_reg;
	logic [DIV_W+3:0] cfg_reg;
	wire  [DIV_W+3:0] cfg = {clock_source_select_in, vco_bypass_in,
		prescaler_divider_field_in, osc_use_internal_in};
	wire              steady = cnt_reg >= 8'h08;
	wire              psrc = osc_use_internal_in ? internal_clock_in : oscillator_input_pin_in;
	wire              f0 = prescaler_divider_field_in == '0;
	wire  [3:0]       exp_src = clock_source_select_in == SCS_SEL_DIRECT ? SCS_SRC_DIRECT :
		clock_source_select_in != SCS_SEL_PRESC ? SCS_SRC_WAKEUP :
		vco_bypass_in ? SCS_SRC_PRESC : SCS_SRC_PLL;
	// cycles of unchanged configuration, so checks skip switch-over
	always_ff @(posedge ref_clk_in) begin
		cfg_reg <= cfg;
		cnt_reg <= (sys_rst_in || cfg != cfg_reg) ? 8'h00 : cnt_reg + {7'h00, cnt_reg != 8'hff};
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	a_src_decode: assert property (cnt_reg == 8'h28 |-> active_source_out == exp_src)
		else $error("source decode wrong");
	a_direct_follow: assert property (steady && active_source_out == SCS_SRC_DIRECT &&
		$past(active_source_out, 3) == SCS_SRC_DIRECT |-> sys_clk_out == $past(direct_clock_input_in, 3))
		else $error("direct path wrong");
	a_wake_follow: assert property (steady && active_source_out == SCS_SRC_WAKEUP &&
		$past(active_source_out, 3) == SCS_SRC_WAKEUP |-> sys_clk_out == $past(wakeup_clock_in, 3))
		else $error("wakeup path wrong");
	a_pll_follow: assert property (steady && active_source_out == SCS_SRC_PLL &&
		$past(active_source_out, 3) == SCS_SRC_PLL |-> sys_clk_out == $past(pll_clock_in, 3))
		else $error("pll path wrong");
	a_presc_unity: assert property (steady && f0 && active_source_out == SCS_SRC_PRESC &&
		$past(active_source_out, 3) == SCS_SRC_PRESC |-> sys_clk_out == $past(psrc, 3))
		else $error("unity prescaler wrong");
	a_div_gap: assert property (steady && !f0 && active_source_out == SCS_SRC_PRESC &&
		$rose(sys_clk_out) |=> (!$rose(sys_clk_out)) [*3]) else $error("divided clock too fast");
	a_src_onehot: assert property ($onehot(active_source_out))
		else $error("source not one-hot");
	a_reset_state: assert property (disable iff (1'b0) sys_rst_in |=> !sys_clk_out &&
		active_source_out == SCS_SRC_WAKEUP) else $error("reset state wrong");
endmodule // scs_clock_select_props
bind scs_clock_select scs_clock_select_props #(.DIV_W(DIV_W)) u_props (.*);

/* File: system_clock_source_select_tb_top.sv */
// self-checking bench for the clock source selector
`timescale 1ns/1ps
module system_clock_source_select_tb_top;
	import scs_pkg::*;
	logic        ref_clk_in = 1'b0, sys_rst_in = 1'b1, vco_bypass_in = 1'b0, osc_use_internal_in = 1'b0;
	logic [1:0]  clock_source_select_in = 2'h0;
	logic [9:0]  prescaler_divider_field_in = 10'h000;
	logic [7:0]  ph = 8'h00;
	logic [31:0] lfsr = 32'h1cfd_8638;
	logic        sys_clk_out;
	logic [3:0]  active_source_out;
	int          fails = 0, num_checks = 0, cyc = 0;
	// slow sources, well under half the sampling rate
	wire direct_clock_input_in = ph[1];
	wire oscillator_input_pin_in = ph[2];
	wire internal_clock_in = ph[3];
	wire pll_clock_in = ~ph[2];
	wire wakeup_clock_in = ph[4];
	scs_clock_select dut (.*);
	initial forever #25 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) #1 ph <= ph + 8'h01;
	always @(posedge ref_clk_in) if (++cyc == 60000) begin
		fails++;
		print_verdict;
	end
	task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic print_verdict;
		if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic [31:0] nxt(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [3:0] exp_src(logic [1:0] s, logic b);
		return s == SCS_SEL_DIRECT ? SCS_SRC_DIRECT : s != SCS_SEL_PRESC ? SCS_SRC_WAKEUP :
			b ? SCS_SRC_PRESC : SCS_SRC_PLL;
	endfunction
	task automatic setcfg(logic [1:0] s, logic b, logic [9:0] f, logic i);
		@(posedge ref_clk_in) #1;
		{clock_source_select_in, vco_bypass_in, prescaler_divider_field_in, osc_use_internal_in}
			= {s, b, f, i};
	endtask
	// period of the divided clock, from the second rise to the third
	task automatic measure(logic [9:0] f, logic i);
		int n;
		setcfg(SCS_SEL_PRESC, 1'b1, f, i);
		repeat (2) @(posedge sys_clk_out);
		n = cyc;
		@(posedge sys_clk_out);
		check("divided period", 16'(cyc - n), 16'((f + 1) * (i ? 16 : 8)));
	endtask
	initial begin
		repeat (16) @(posedge ref_clk_in);
		#1;
		check("reset source", active_source_out, SCS_SRC_WAKEUP);
		check("reset clock", sys_clk_out, 16'h0000);
		sys_rst_in = 1'b0;
		for (int m = 0; m < 8; m++) begin
			lfsr = nxt(lfsr);
			setcfg(m[2:1], m[0], 10'h000, lfsr[0]);
			repeat (60) @(posedge ref_clk_in);
			check("active source", active_source_out, exp_src(m[2:1], m[0]));
		end
		measure(10'h000, 1'b0);
		measure(10'h001, 1'b1);
		repeat (2) begin
			lfsr = nxt(lfsr);
			measure(10'(lfsr[2:0]) + 10'h001, lfsr[3]);
		end
		measure(10'h3ff, 1'b0);
		print_verdict;
	end
endmodule // system_clock_source_select_tb_top
